// ==== common/lsc_defines.vh ====
`ifndef LSC_DEFINES_VH
`define LSC_DEFINES_VH

// cluster shape
`define LSC_SLICES      8
`define LSC_ENTRY_LO    0
`define LSC_ENTRY_HI    4
`define LSC_LUT_BITS    16

// register data source select
`define LSC_SRC_SUM     2'h0
`define LSC_SRC_LUT     2'h1
`define LSC_SRC_PACK    2'h2
`define LSC_SRC_CHAIN   2'h3

// register values
`define LSC_CLR_VAL     1'h0
`define LSC_PRESET_VAL  1'h1
`define LSC_RST_VAL     1'h0

`endif

// ==== design/lsc_logic_slice.v ====
`timescale 1ns/1ps
`default_nettype none
`include "lsc_defines.vh"

module lsc_logic_slice
(
  input  wire        clk,          // cluster clock
  input  wire        rst,          // sync reset, high
  input  wire        ce,           // global freeze, high runs
  input  wire        chipClr,      // chip-wide clear, high
  input  wire        dataA,        // shared lut input
  input  wire        dataB,        // shared lut input
  input  wire [1:0]  dataC,        // per-half input
  input  wire [1:0]  dataD,        // per-half input
  input  wire [1:0]  dataE,        // third addend, shared mode
  input  wire        packingInLo,  // packing input, low register
  input  wire        packingInHi,  // packing input, high register
  input  wire [63:0] lutMask,      // four 16-bit lut masks
  input  wire        sharedMode,   // three-input add mode
  input  wire        sub,          // subtract
  input  wire        cntEn,        // counter enable
  input  wire        carryIn,      // carry into low adder
  input  wire        shareIn,      // shared chain in
  input  wire        regChainIn,   // register chain in
  input  wire        regEn,        // register clock enable
  input  wire        syncClr,      // cluster sync clear
  input  wire        syncLoad,     // cluster sync load
  input  wire [1:0]  syncData,     // sync load value
  input  wire [1:0]  asyncClr,     // selected clear per register
  input  wire        asyncLoad,    // cluster load/preset
  input  wire        presetMode,   // load constant one
  input  wire [1:0]  regSrc,       // register data source
  output wire [1:0]  sum,          // unregistered adder sums
  output wire [1:0]  lutOut,       // lut combinational outputs
  output wire        carryOut,     // high adder carry
  output wire        shareOut,     // shared chain out
  output wire [1:0]  q             // register outputs
);

  function lut4;
    input [15:0] mask;
    input [3:0]  sel;
    begin
      lut4 = mask[sel];
    end
  endfunction

  wire [2:0] c;
  wire [2:0] sh;
  assign c[0]     = carryIn;
  assign sh[0]    = shareIn;
  assign carryOut = c[2];
  assign shareOut = sh[2];

  genvar h;
  generate
    for (h = 0; h < 2; h = h + 1)
    begin : g_half
      wire [3:0] sel = {dataD[h], dataC[h], dataB, dataA};
      wire opX = lut4(lutMask[32*h +: 16], sel);
      wire opY = lut4(lutMask[32*h+16 +: 16], sel);
      wire opYe = (cntEn & opY) ^ sub;
      wire s3 = dataC[h] ^ dataD[h] ^ dataE[h];
      wire k3 = (dataC[h] & dataD[h]) | (dataE[h] & (dataC[h] | dataD[h]));
      wire addA = sharedMode ? s3 : opX;
      wire addB = sharedMode ? sh[h] : opYe;
      assign sum[h]    = addA ^ addB ^ c[h];
      assign c[h+1]    = (addA & addB) | (c[h] & (addA | addB));
      assign sh[h+1]   = sharedMode & k3;
      assign lutOut[h] = opX;

      wire pack  = (h == 0) ? packingInLo : packingInHi;
      wire chain = (h == 0) ? regChainIn : q[0];
      wire aData = presetMode ? `LSC_PRESET_VAL : pack;
      reg  d;
      reg  qh;
      assign q[h] = qh;
      always @*
      begin
        case (regSrc)
          `LSC_SRC_SUM:   d = sum[h];
          `LSC_SRC_LUT:   d = opX;
          `LSC_SRC_PACK:  d = pack;
          `LSC_SRC_CHAIN: d = chain;
          default:        d = sum[h];
        endcase
      end

      always @(posedge clk)
      begin
        if (chipClr)
          qh <= `LSC_CLR_VAL;
        else if (rst)
          qh <= `LSC_RST_VAL;
        else if (ce)
        begin
          if (asyncClr[h])
            qh <= `LSC_CLR_VAL;
          else if (asyncLoad)
            qh <= aData;
          else if (regEn)
          begin
            if (syncClr)
              qh <= `LSC_CLR_VAL;
            else if (syncLoad)
              qh <= syncData[h];
            else
              qh <= d;
          end
        end
      end
    end
  endgenerate

endmodule // lsc_logic_slice

`default_nettype wire

// ==== design/lsc_slice_cluster.v ====
// Functional notes
// - two full adders per slice, lut-fed
// - all four luts share dataA, dataB
// - carry ripples low, high, next slice
// - registered and unregistered adder results available
// - carry usable with lut outputs, sum ignored
// - subtract routed carry high when first less
// - sync load picks load data, else data
// - enables, up/down, add/sub from local inputs
// - sync clear, load act cluster-wide
// - chains start slice 0 or 4
// - long chains link to following clusters
// - half chains continue into same half
// - column parity chooses bypassable half
// - shared mode does three-input add
// - shared carry feeds next adder
// - shared chains start 0/4, same bypass
// - packing inputs still feed registers
// - register chain forms independent shift register
// - preset is async load of one
// - clear wins over load/preset
// - two clears, one load/preset per cluster
// - enabled chip clear overrides everything
// - two registers per slice, full controls
// - async load data from packing inputs
`timescale 1ns/1ps
`default_nettype none
`include "lsc_defines.vh"

module lsc_slice_cluster
#(
  parameter SLICES         = `LSC_SLICES,
  parameter BYPASS_TOP_COL = 1
)
(
  input  wire                clk,           // cluster clock
  input  wire                rst,           // sync reset, high
  input  wire                ce,            // freeze when low
  input  wire                chipClearN,    // chip-wide clear, low
  input  wire                chipClearEn,   // chip clear option
  input  wire                sharedMode,    // shared arithmetic mode
  input  wire                addSub,        // high subtracts
  input  wire                upDown,        // high counts up
  input  wire                cntEn,         // counter enable
  input  wire                regEn,         // register clock enable
  input  wire                syncClr,       // cluster sync clear
  input  wire                syncLoad,      // cluster sync load
  input  wire                asyncClrA,     // first clear
  input  wire                asyncClrB,     // second clear
  input  wire [2*SLICES-1:0] clrSel,        // per register: 1 picks B
  input  wire                asyncLoad,     // load/preset
  input  wire                presetMode,    // load one, not data
  input  wire                startLo,       // chain starts at slice 0
  input  wire                startHi,       // chain starts at slice 4
  input  wire                halfChain,     // half-cluster chains
  input  wire                bypassHalf,    // bypass one half
  input  wire                routeFromTop,  // route top half carry
  input  wire                carryInTop,    // prev cluster top exit
  input  wire                carryInBot,    // prev cluster bottom exit
  input  wire                shareInTop,    // prev shared top exit
  input  wire                shareInBot,    // prev shared bottom exit
  input  wire                regChainIn,    // register chain in
  input  wire [SLICES-1:0]   dataA,         // shared lut input
  input  wire [SLICES-1:0]   dataB,         // shared lut input
  input  wire [2*SLICES-1:0] dataC,         // per-half input
  input  wire [2*SLICES-1:0] dataD,         // per-half input
  input  wire [2*SLICES-1:0] dataE,         // third addend
  input  wire [SLICES-1:0]   packingInLo,   // low packing inputs
  input  wire [SLICES-1:0]   packingInHi,   // high packing inputs
  input  wire [2*SLICES-1:0] syncData,      // sync load values
  input  wire [63:0]         lutMask,       // lut masks
  input  wire [1:0]          regSrc,        // register data source
  output wire [2*SLICES-1:0] regQ,          // register outputs
  output wire [2*SLICES-1:0] sumComb,       // unregistered sums
  output wire [2*SLICES-1:0] lutComb,       // lut outputs
  output wire                carryOutTop,   // top half exit
  output wire                carryOutBot,   // bottom half exit
  output wire                shareOutTop,   // shared top exit
  output wire                shareOutBot,   // shared bottom exit
  output wire                carryRoute,    // final carry to routing
  output reg                 carryRouteQ,   // registered routing carry
  output wire                regChainOut    // register chain out
);

  localparam ENTRY_HI = `LSC_ENTRY_HI;

  // subtract when add/sub asks for it, flipped when counting down
  wire sub     = addSub ^ ~upDown;
  wire chipClr = chipClearEn & ~chipClearN;

  wire bypassTop = bypassHalf & (BYPASS_TOP_COL != 0);
  wire bypassBot = bypassHalf & (BYPASS_TOP_COL == 0);

  wire [SLICES:0]   cy;
  wire [SLICES:0]   sh;
  wire [SLICES-1:0] cyIn;
  wire [SLICES-1:0] shIn;
  wire [SLICES-1:0] sliceCout;
  wire [SLICES-1:0] sliceShOut;
  wire [SLICES:0]   rc;

  assign rc[0]       = regChainIn;
  assign regChainOut = rc[SLICES];

  genvar i;
  generate
    for (i = 0; i < SLICES; i = i + 1)
    begin : g_slice
      if (i == `LSC_ENTRY_LO)
      begin : g_lo
        // full chains enter from the bottom exit, half chains top to top
        assign cyIn[i] = startLo ? sub :
                         (halfChain ? carryInTop : carryInBot);
        assign shIn[i] = startLo ? 1'b0 :
                         (halfChain ? shareInTop : shareInBot);
      end
      else if (i == ENTRY_HI)
      begin : g_hi
        assign cyIn[i] = startHi ? sub :
                         (halfChain ? carryInBot : cy[i]);
        assign shIn[i] = startHi ? 1'b0 :
                         (halfChain ? shareInBot : sh[i]);
      end
      else
      begin : g_mid
        assign cyIn[i] = cy[i];
        assign shIn[i] = sh[i];
      end

      assign cy[i+1] = sliceCout[i];
      assign sh[i+1] = sliceShOut[i];

      lsc_logic_slice u_slice
      (
        .clk         (clk),
        .rst         (rst),
        .ce          (ce),
        .chipClr     (chipClr),
        .dataA       (dataA[i]),
        .dataB       (dataB[i]),
        .dataC       (dataC[2*i +: 2]),
        .dataD       (dataD[2*i +: 2]),
        .dataE       (dataE[2*i +: 2]),
        .packingInLo (packingInLo[i]),
        .packingInHi (packingInHi[i]),
        .lutMask     (lutMask),
        .sharedMode  (sharedMode),
        .sub         (sub),
        .cntEn       (cntEn),
        .carryIn     (cyIn[i]),
        .shareIn     (shIn[i]),
        .regChainIn  (rc[i]),
        .regEn       (regEn),
        .syncClr     (syncClr),
        .syncLoad    (syncLoad),
        .syncData    (syncData[2*i +: 2]),
        .asyncClr    ({clrSel[2*i+1] ? asyncClrB : asyncClrA,
                       clrSel[2*i] ? asyncClrB : asyncClrA}),
        .asyncLoad   (asyncLoad),
        .presetMode  (presetMode),
        .regSrc      (regSrc),
        .sum         (sumComb[2*i +: 2]),
        .lutOut      (lutComb[2*i +: 2]),
        .carryOut    (sliceCout[i]),
        .shareOut    (sliceShOut[i]),
        .q           (regQ[2*i +: 2])
      );

      assign rc[i+1] = regQ[2*i+1];
    end
  endgenerate

  // a bypassed half hands the incoming chain straight to the next cluster
  assign carryOutTop = bypassTop ? carryInTop : sliceCout[ENTRY_HI-1];
  assign carryOutBot = bypassBot ? carryInBot : sliceCout[SLICES-1];
  assign shareOutTop = bypassTop ? shareInTop : sliceShOut[ENTRY_HI-1];
  assign shareOutBot = bypassBot ? shareInBot : sliceShOut[SLICES-1];

  // routed carry is a borrow when subtracting: high means first < second
  wire chainEnd = (halfChain & routeFromTop) ? sliceCout[ENTRY_HI-1]
                                             : sliceCout[SLICES-1];
  assign carryRoute = sub ? ~chainEnd : chainEnd;

  always @(posedge clk)
  begin
    if (chipClr)
      carryRouteQ <= `LSC_CLR_VAL;
    else if (rst)
      carryRouteQ <= `LSC_RST_VAL;
    else if (ce)
      carryRouteQ <= carryRoute;
  end

endmodule // lsc_slice_cluster

`default_nettype wire

// ==== testbench/lsc_cluster_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module lsc_cluster_sva #(parameter SLICES = 8)
(
  input wire logic clk, rst, ce, chipClearN, chipClearEn, regEn,
  input wire logic syncClr, syncLoad, asyncClrA, asyncClrB, asyncLoad,
  input wire logic presetMode, regChainIn, carryRoute, carryRouteQ,
  input wire logic [1:0] regSrc,
  input wire logic [2*SLICES-1:0] syncData, regQ
);
  wire chip = chipClearEn && !chipClearN;
  wire live = ce && !rst && !chip;
  wire calm = live && regEn && !asyncLoad && !asyncClrA && !asyncClrB;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chip_clear_a: assert property (
    chip |=> regQ == '0) else $error("chip clear missed");
  freeze_hold_a: assert property (
    !ce && !chip && !rst |=> $stable(regQ)) else $error("freeze broken");
  sync_clear_a: assert property (
    calm && syncClr |=> regQ == '0) else $error("sync clear missed");
  sync_load_a: assert property (
    calm && !syncClr && syncLoad |=> regQ == $past(syncData))
    else $error("sync load missed");
  preset_one_a: assert property (
    live && asyncLoad && presetMode && !asyncClrA && !asyncClrB |=> &regQ)
    else $error("preset missed");
  clear_wins_a: assert property (
    live && asyncClrA && asyncClrB |=> regQ == '0) else $error("clear lost");
  route_flop_a: assert property (
    live |=> carryRouteQ == $past(carryRoute)) else $error("route flop");
  reg_chain_a: assert property (
    calm && !syncClr && !syncLoad && regSrc == 2'h3 |=>
      regQ == {$past(regQ[2*SLICES-2:0]), $past(regChainIn)})
    else $error("chain shift broken");
  cover property (calm && syncLoad && !syncClr);
  cover property (chip && !ce);
  cover property (calm && regSrc == 2'h3);
endmodule // lsc_cluster_sva
bind lsc_slice_cluster lsc_cluster_sva #(.SLICES(SLICES)) chk
(
  .clk(clk), .rst(rst), .ce(ce), .chipClearN(chipClearN),
  .chipClearEn(chipClearEn), .regEn(regEn), .syncClr(syncClr),
  .syncLoad(syncLoad), .asyncClrA(asyncClrA), .asyncClrB(asyncClrB),
  .asyncLoad(asyncLoad), .presetMode(presetMode), .regChainIn(regChainIn),
  .carryRoute(carryRoute), .carryRouteQ(carryRouteQ), .regSrc(regSrc),
  .syncData(syncData), .regQ(regQ)
);
`default_nettype wire

// ==== testbench/lsc_prev_cluster.sv ====
`timescale 1ns/1ps
`default_nettype none
// the cluster below: its half exits and last register feed this one
module lsc_prev_cluster
(
  input  wire logic       clk,
  input  wire logic [3:0] exits,    // carry top/bot, share top/bot
  input  wire logic       chainBit, // into its last register
  output logic            carryTop,
  output logic            carryBot,
  output logic            shareTop,
  output logic            shareBot,
  output logic            chainOut
);
  assign {carryTop, carryBot, shareTop, shareBot} = exits;
  always @(posedge clk)
  begin
    chainOut <= chainBit;
  end
endmodule // lsc_prev_cluster
`default_nettype wire

// ==== testbench/lsc_slice_cluster_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module lsc_slice_cluster_test;
  logic clk, rst, ce, chipClearN, chipClearEn, sharedMode, addSub, upDown;
  logic cntEn, regEn, syncClr, syncLoad, asyncClrA, asyncClrB, asyncLoad;
  logic presetMode, startLo, startHi, halfChain, bypassHalf, routeFromTop;
  logic carryInTop, carryInBot, shareInTop, shareInBot, regChainIn, chainBit;
  logic carryOutTop, carryOutBot, shareOutTop, shareOutBot, carryRoute;
  logic carryRouteQ, regChainOut;
  logic [7:0] dataA, dataB, packingInLo, packingInHi;
  logic [15:0] clrSel, dataC, dataD, dataE, syncData, regQ, sumComb, lutComb;
  logic [63:0] lutMask;
  logic [3:0] exits;
  logic [1:0] regSrc;
  int miscompares, compares, cycles;
  lsc_slice_cluster dut (.clk(clk), .rst(rst), .ce(ce),
    .chipClearN(chipClearN), .chipClearEn(chipClearEn),
    .sharedMode(sharedMode), .addSub(addSub), .upDown(upDown),
    .cntEn(cntEn), .regEn(regEn), .syncClr(syncClr), .syncLoad(syncLoad),
    .asyncClrA(asyncClrA), .asyncClrB(asyncClrB), .clrSel(clrSel),
    .asyncLoad(asyncLoad), .presetMode(presetMode), .startLo(startLo),
    .startHi(startHi), .halfChain(halfChain), .bypassHalf(bypassHalf),
    .routeFromTop(routeFromTop), .carryInTop(carryInTop),
    .carryInBot(carryInBot), .shareInTop(shareInTop),
    .shareInBot(shareInBot), .regChainIn(regChainIn), .dataA(dataA),
    .dataB(dataB), .dataC(dataC), .dataD(dataD), .dataE(dataE),
    .packingInLo(packingInLo), .packingInHi(packingInHi),
    .syncData(syncData), .lutMask(lutMask), .regSrc(regSrc), .regQ(regQ),
    .sumComb(sumComb), .lutComb(lutComb), .carryOutTop(carryOutTop),
    .carryOutBot(carryOutBot), .shareOutTop(shareOutTop),
    .shareOutBot(shareOutBot), .carryRoute(carryRoute),
    .carryRouteQ(carryRouteQ), .regChainOut(regChainOut));
  lsc_prev_cluster nbr (.clk(clk), .exits(exits), .chainBit(chainBit),
    .carryTop(carryInTop), .carryBot(carryInBot), .shareTop(shareInTop),
    .shareBot(shareInBot), .chainOut(regChainIn));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      miscompares++;
      conclude();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic conclude;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // x and y ride the two lut operands, e is the third addend
  task automatic arith(input logic shr, s, input logic [15:0] x, y, e);
    logic [16:0] r;
    r = s ? {1'b0, x} - {1'b0, y} : x + y + e;
    {sharedMode, addSub, regSrc} = {shr, s, 1'b0, s};
    {dataC, dataD, dataE, syncData} = {x, y, e, y};
    syncLoad = s & r[16];
    @(negedge clk);
    `CHK(sumComb, r[15:0])
    `CHK(lutComb, x)
    if (shr)
      `CHK(shareOutBot, (x[15] & y[15]) | (e[15] & (x[15] | y[15])))
    else
      `CHK(carryOutBot, s ^ r[16])
    step(1);
    `CHK(regQ, s ? (r[16] ? y : x) : r[15:0])
    if (!shr)
    begin
      `CHK(carryRoute, r[16])
      `CHK(carryRouteQ, r[16])
    end
  endtask
  task automatic t_regs;
    {syncClr, syncLoad, syncData} = {2'h3, 16'hffff};
    step(1);
    `CHK(regQ, 16'h0000)
    {regEn, syncClr} = 2'h0;
    step(1);
    `CHK(regQ, 16'h0000)
    regEn = 1'b1;
    step(1);
    `CHK(regQ, 16'hffff)
    {syncClr, syncLoad, regSrc, chainBit} = 5'h17;
    step(1);
    {syncClr, chainBit} = 2'h0;
    step(4);
    `CHK(regQ, 16'h0008)
  endtask
  task automatic t_async;
    {asyncLoad, presetMode} = 2'h3;
    step(1);
    `CHK(regQ, 16'hffff)
    `CHK(regChainOut, 1'b1)
    {ce, chipClearEn, chipClearN} = 3'h2;
    step(1);
    `CHK(regQ, 16'h0000)
    {chipClearEn, chipClearN} = 2'h1;
    step(1);
    `CHK(regQ, 16'h0000)
    {ce, presetMode} = 2'h2;
    {packingInHi, packingInLo} = 16'hf00f;
    step(1);
    `CHK(regQ, 16'haa55)
    {presetMode, asyncClrA, clrSel} = {2'h3, 16'hff00};
    step(1);
    `CHK(regQ, 16'hff00)
    asyncClrB = 1'b1;
    step(1);
    `CHK(regQ, 16'h0000)
    {asyncLoad, asyncClrA, asyncClrB} = 3'h0;
  endtask
  task automatic t_half;
    {sharedMode, startLo, halfChain, bypassHalf} = 4'h3;
    {dataC, dataD, exits} = {32'h0, 4'h8};
    @(negedge clk);
    `CHK(sumComb, 16'h0001)
    `CHK(carryOutTop, 1'b1)
    step(1);
    {startHi, exits} = 5'h1e;
    @(negedge clk);
    `CHK(sumComb, 16'h0001)
    `CHK(shareOutTop, 1'b1)
  endtask
  // counting down with counter enable off, packing source, top-half route
  task automatic t_ctrl;
    {startLo, halfChain, bypassHalf, startHi, addSub, upDown} = 6'h20;
    {cntEn, regSrc, dataC, dataD} = {3'h2, 16'h1234, 16'h00ff};
    @(negedge clk);
    `CHK(sumComb, 16'h1234)
    `CHK(carryRoute, 1'b0)
    step(1);
    `CHK(regQ, 16'haa55)
    {cntEn, halfChain, routeFromTop, dataC} = {3'h7, 16'h0100};
    @(negedge clk);
    `CHK(carryRoute, 1'b1)
    step(1);
    {lutMask[15:0], lutMask[47:32], dataB} = {{2{16'hcccc}}, 8'h0f};
    @(negedge clk);
    `CHK(lutComb, 16'h00ff)
  endtask
  initial
  begin
    {rst, ce, chipClearN, upDown, cntEn, regEn, startLo} = 7'h7f;
    {chipClearEn, syncClr, syncLoad, asyncClrA, asyncClrB, asyncLoad} = '0;
    {presetMode, startHi, halfChain, bypassHalf, routeFromTop} = '0;
    {sharedMode, addSub, regSrc, chainBit, exits} = '0;
    {dataA, dataB, packingInLo, packingInHi} = '0;
    {clrSel, dataC, dataD, dataE, syncData} = '0;
    // low operand follows dataC, high operand follows dataD
    lutMask = {2{16'hff00, 16'hf0f0}};
    step(3);
    rst = 1'b0;
    arith(1'b0, 1'b0, 16'hffff, 16'h0001, 16'h0);
    arith(1'b0, 1'b0, 16'h1234, 16'h4321, 16'h0);
    arith(1'b0, 1'b1, 16'h0005, 16'h0009, 16'h0);
    arith(1'b0, 1'b1, 16'h9000, 16'h0100, 16'h0);
    arith(1'b0, 1'b1, 16'h0007, 16'h0007, 16'h0);
    arith(1'b1, 1'b0, 16'h9357, 16'ha468, 16'h0f0f);
    t_regs();
    t_async();
    t_half();
    t_ctrl();
    conclude();
  end
endmodule // lsc_slice_cluster_test
`default_nettype wire
